//--- hdl/serial_pkg.sv
// Shared constants of the asynchronous serial core: register offsets, bit positions, resets.
// Assumes one system clock and a plain register port of eight-bit words.
package serial_pkg;
    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [2:0] OFS_MODE   = 3'h0;
    localparam logic [2:0] OFS_CTRL   = 3'h1;
    localparam logic [2:0] OFS_TXBUF  = 3'h2;
    localparam logic [2:0] OFS_STATUS = 3'h3;
    localparam logic [2:0] OFS_RXBUF  = 3'h4;
    localparam logic [2:0] OFS_DIV    = 3'h5;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int MODE_SYNC   = 7;
    localparam int MODE_SEVEN  = 6;
    localparam int MODE_PAR    = 5;
    localparam int MODE_ODD    = 4;
    localparam int MODE_STOP2  = 3;
    localparam int MODE_MP     = 2;
    localparam int CTRL_TXIE   = 7;
    localparam int CTRL_RXIE   = 6;
    localparam int CTRL_TXON   = 5;
    localparam int CTRL_RXON   = 4;
    localparam int CTRL_TDIE   = 2;
    localparam int CTRL_CKHI   = 1;
    localparam int CTRL_CKLO   = 0;
    localparam int ST_TX_BUF_EMPTY_FLAG     = 7;
    localparam int ST_RX_BUF_FULL_FLAG     = 6;
    localparam int ST_OVR      = 5;
    localparam int ST_FRM      = 4;
    localparam int ST_PAR      = 3;
    localparam int ST_TX_DONE_FLAG     = 2;
    localparam int ST_MPB_RX   = 1;
    localparam int ST_MPB_TX   = 0;
    // ------------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_MODE   = 8'h00;
    localparam logic [7:0] RST_CTRL   = 8'h00;
    localparam logic [7:0] RST_DIV    = 8'h00;
    localparam logic [3:0] SUB_SAMPLE = 4'h7;
    localparam logic [3:0] SUB_LAST   = 4'hf;
    localparam logic [1:0] CK_INT     = 2'b00;
    localparam logic [1:0] CK_INT_OUT = 2'b01;
    localparam logic [1:0] CK_EXT     = 2'b10;
endpackage : serial_pkg

//--- hdl/async_serial_tx_rx_core.sv
// Asynchronous transmit and receive core with holding buffers and a 16x bit clock.
// Assumes RX_LINE and SCK_I come from pins and software drives the register port.
//
// Added by the designer: strobed register access and the address map.
module async_serial_tx_rx_core
    import serial_pkg::*;
(
    input  wire logic       CLK_SYS,
    input  wire logic       RSTN,
    input  wire logic [2:0] ADDR,
    input  wire logic [7:0] WR_DATA,
    input  wire logic       WR_STB,
    input  wire logic       RD_STB,
    output logic      [7:0] RD_DATA,
    input  wire logic       RX_LINE,
    output logic            TX_LINE,
    input  wire logic       SCK_I,
    output logic            SCK_O,
    output logic            SCK_OE,
    output logic            IRQ_RX_FULL,
    output logic            IRQ_TX_EMPTY,
    output logic            IRQ_TX_DONE
);
    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_START = 3'b001,
        S_DATA  = 3'b010,
        S_EXTRA = 3'b011,
        S_STOP  = 3'b100
    } phase_t;

    // ------------------------------------------------------------------
    // Frame format helpers
    // ------------------------------------------------------------------
    function automatic logic [2:0] last_data_idx(input logic [7:0] m);
        if (m[MODE_PAR] && m[MODE_MP])
            return 3'h4;
        else if (m[MODE_SEVEN])
            return 3'h6;
        else
            return 3'h7;
    endfunction : last_data_idx

    function automatic logic has_parity(input logic [7:0] m);
        return m[MODE_PAR] && (!m[MODE_MP] || m[MODE_SEVEN]);
    endfunction : has_parity

    function automatic logic has_mpb(input logic [7:0] m);
        return m[MODE_MP] && !m[MODE_PAR];
    endfunction : has_mpb

    function automatic logic par_of(input logic [7:0] d, input logic [7:0] m);
        logic [7:0] msk;
        msk = 8'hff >> (3'h7 - last_data_idx(m));
        return (^(d & msk)) ^ m[MODE_ODD];
    endfunction : par_of

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] mode_ff;
    logic [7:0] ctrl_ff;
    logic [7:0] div_ff;
    logic [7:0] tx_buffer_ff;
    logic [7:0] rx_buffer_ff;
    logic       tx_buf_empty_flag_ff;
    logic       rx_buf_full_flag_ff;
    logic       ovr_ff;
    logic       frm_ff;
    logic       per_ff;
    logic       tx_done_flag_ff;
    logic       mpb_rx_ff;
    logic       mpb_tx_ff;

    logic wr_status;
    logic tx_load;
    logic tx_finish;
    logic rx_done;
    logic rx_err_any;
    logic nxt_ovr;
    logic nxt_frm;
    logic nxt_per;

    assign wr_status = WR_STB && (ADDR == OFS_STATUS);

    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
        begin
            mode_ff <= RST_MODE;
            ctrl_ff <= RST_CTRL;
            div_ff  <= RST_DIV;
        end
        else if (WR_STB)
        begin
            if (ADDR == OFS_MODE)
                mode_ff <= WR_DATA;
            if (ADDR == OFS_CTRL)
                ctrl_ff <= WR_DATA;
            if (ADDR == OFS_DIV)
                div_ff <= WR_DATA;
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
        begin
            tx_buffer_ff <= 8'h00;
            mpb_tx_ff    <= 1'b0;
        end
        else
        begin
            if (WR_STB && ADDR == OFS_TXBUF)
                tx_buffer_ff <= WR_DATA;
            if (wr_status)
                mpb_tx_ff <= WR_DATA[ST_MPB_TX];
        end
    end

    // Flags clear on a written zero; a hardware set in the same cycle wins.
    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
        begin
            tx_buf_empty_flag_ff <= 1'b1;
            tx_done_flag_ff <= 1'b1;
        end
        else
        begin
            if (!ctrl_ff[CTRL_TXON] || tx_load)
                tx_buf_empty_flag_ff <= 1'b1;
            else if (wr_status && !WR_DATA[ST_TX_BUF_EMPTY_FLAG])
                tx_buf_empty_flag_ff <= 1'b0;
            if (tx_finish && tx_buf_empty_flag_ff)
                tx_done_flag_ff <= 1'b1;
            else if (tx_load || (wr_status && !WR_DATA[ST_TX_BUF_EMPTY_FLAG]))
                tx_done_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
        begin
            rx_buf_full_flag_ff <= 1'b0;
            ovr_ff  <= 1'b0;
            frm_ff  <= 1'b0;
            per_ff  <= 1'b0;
        end
        else
        begin
            if (rx_done && !rx_buf_full_flag_ff && !nxt_frm && !nxt_per)
                rx_buf_full_flag_ff <= 1'b1;
            else if (wr_status && !WR_DATA[ST_RX_BUF_FULL_FLAG])
                rx_buf_full_flag_ff <= 1'b0;
            if (rx_done && nxt_ovr)
                ovr_ff <= 1'b1;
            else if (wr_status && !WR_DATA[ST_OVR])
                ovr_ff <= 1'b0;
            if (rx_done && nxt_frm)
                frm_ff <= 1'b1;
            else if (wr_status && !WR_DATA[ST_FRM])
                frm_ff <= 1'b0;
            if (rx_done && nxt_per)
                per_ff <= 1'b1;
            else if (wr_status && !WR_DATA[ST_PAR])
                per_ff <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
            RD_DATA <= 8'h00;
        else if (RD_STB)
        begin
            unique case (ADDR)
                OFS_MODE:   RD_DATA <= mode_ff;
                OFS_CTRL:   RD_DATA <= ctrl_ff;
                OFS_TXBUF:  RD_DATA <= tx_buffer_ff;
                OFS_STATUS: RD_DATA <= {tx_buf_empty_flag_ff, rx_buf_full_flag_ff, ovr_ff, frm_ff,
                                        per_ff, tx_done_flag_ff, mpb_rx_ff, mpb_tx_ff};
                OFS_RXBUF:  RD_DATA <= rx_buffer_ff;
                OFS_DIV:    RD_DATA <= div_ff;
                default:    RD_DATA <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
        begin
            IRQ_RX_FULL  <= 1'b0;
            IRQ_TX_EMPTY <= 1'b0;
            IRQ_TX_DONE  <= 1'b0;
        end
        else
        begin
            IRQ_RX_FULL  <= rx_buf_full_flag_ff && ctrl_ff[CTRL_RXIE];
            IRQ_TX_EMPTY <= tx_buf_empty_flag_ff && ctrl_ff[CTRL_TXIE] && ctrl_ff[CTRL_TXON];
            IRQ_TX_DONE  <= tx_done_flag_ff && ctrl_ff[CTRL_TDIE] && ctrl_ff[CTRL_TXON];
        end
    end

    // ------------------------------------------------------------------
    // Bit clock selection
    // ------------------------------------------------------------------
    logic [2:0] sck_sync_ff;
    logic [2:0] rx_sync_ff;
    logic       sck_s_ff;
    logic       rx_s_ff;
    logic       rx_prev_ff;
    logic [7:0] div_cnt_ff;
    logic [1:0] ck_sel;
    logic       tick;

    assign ck_sel = {ctrl_ff[CTRL_CKHI], ctrl_ff[CTRL_CKLO]};

    // Three stages; a change is accepted once the last two agree.
    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
        begin
            sck_sync_ff <= 3'h0;
            rx_sync_ff  <= 3'h7;
            sck_s_ff    <= 1'b0;
            rx_s_ff     <= 1'b1;
        end
        else
        begin
            sck_sync_ff <= {sck_sync_ff[1:0], SCK_I};
            rx_sync_ff  <= {rx_sync_ff[1:0], RX_LINE};
            if (sck_sync_ff[1] == sck_sync_ff[2])
                sck_s_ff <= sck_sync_ff[2];
            if (rx_sync_ff[1] == rx_sync_ff[2])
                rx_s_ff <= rx_sync_ff[2];
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
        begin
            div_cnt_ff <= 8'h00;
            tick       <= 1'b0;
        end
        else if (ck_sel == CK_EXT)
        begin
            div_cnt_ff <= 8'h00;
            tick       <= sck_s_ff && !sck_sync_ff[2] && (sck_sync_ff[1] == sck_sync_ff[2]);
        end
        else
        begin
            tick       <= (div_cnt_ff == div_ff);
            div_cnt_ff <= (div_cnt_ff == div_ff) ? 8'h00 : div_cnt_ff + 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------------
    phase_t     tx_st_ff;
    logic [3:0] tx_sub_ff;
    logic [7:0] tx_shifter_ff;
    logic [2:0] tx_idx_ff;
    logic       tx_extra_ff;
    logic       tx_stop2_ff;
    logic       tx_bit_end;

    // The sub-bit counter free-runs so the clock output keeps a steady phase.
    assign tx_bit_end = tick && (tx_sub_ff == SUB_LAST);
    assign tx_finish  = tx_bit_end && (tx_st_ff == S_STOP) && !tx_stop2_ff;
    assign tx_load    = ctrl_ff[CTRL_TXON] && !tx_buf_empty_flag_ff && tx_bit_end &&
                        ((tx_st_ff == S_IDLE) || tx_finish);

    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
            tx_sub_ff <= 4'h0;
        else if (tick)
            tx_sub_ff <= tx_sub_ff + 4'h1;
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN || !ctrl_ff[CTRL_TXON])
        begin
            tx_st_ff      <= S_IDLE;
            tx_shifter_ff <= 8'h00;
            tx_idx_ff     <= 3'h0;
            tx_extra_ff   <= 1'b0;
            tx_stop2_ff   <= 1'b0;
        end
        else if (tx_load)
        begin
            tx_st_ff      <= S_START;
            tx_shifter_ff <= tx_buffer_ff;
            tx_idx_ff     <= 3'h0;
            tx_extra_ff   <= has_mpb(mode_ff) ? mpb_tx_ff : par_of(tx_buffer_ff, mode_ff);
        end
        else if (tx_bit_end)
        begin
            unique case (tx_st_ff)
                S_IDLE:  tx_st_ff <= S_IDLE;
                S_START: tx_st_ff <= S_DATA;
                S_DATA:
                begin
                    tx_shifter_ff <= tx_shifter_ff >> 1;
                    tx_idx_ff     <= tx_idx_ff + 3'h1;
                    if (tx_idx_ff == last_data_idx(mode_ff))
                    begin
                        tx_st_ff    <= (has_parity(mode_ff) || has_mpb(mode_ff)) ? S_EXTRA
                                                                                : S_STOP;
                        tx_stop2_ff <= mode_ff[MODE_STOP2];
                    end
                end
                S_EXTRA: tx_st_ff <= S_STOP;
                S_STOP:
                begin
                    if (tx_stop2_ff)
                        tx_stop2_ff <= 1'b0;
                    else
                        tx_st_ff <= S_IDLE;
                end
                default: tx_st_ff <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
            TX_LINE <= 1'b1;
        else
        begin
            unique case (tx_st_ff)
                S_START: TX_LINE <= 1'b0;
                S_DATA:  TX_LINE <= tx_shifter_ff[0];
                S_EXTRA: TX_LINE <= tx_extra_ff;
                default: TX_LINE <= 1'b1;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
        begin
            SCK_O  <= 1'b0;
            SCK_OE <= 1'b0;
        end
        else
        begin
            SCK_O  <= tx_sub_ff[3];
            // only code 01 drives the pin
            SCK_OE <= (ck_sel == CK_INT_OUT) && !mode_ff[MODE_SYNC];
        end
    end

    // ------------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------------
    phase_t     rx_st_ff;
    logic [3:0] rx_sub_ff;
    logic [7:0] rx_shifter_ff;
    logic [2:0] rx_idx_ff;
    logic       rx_extra_ff;
    logic       rx_sample;
    logic [7:0] rx_data;

    assign rx_sample  = tick && (rx_sub_ff == SUB_SAMPLE);
    assign rx_done    = rx_sample && (rx_st_ff == S_STOP);
    assign rx_err_any = ovr_ff || frm_ff || per_ff;
    assign rx_data    = rx_shifter_ff >> (3'h7 - last_data_idx(mode_ff));
    assign nxt_ovr    = rx_buf_full_flag_ff;
    assign nxt_frm    = !rx_buf_full_flag_ff && !rx_s_ff;
    assign nxt_per    = !rx_buf_full_flag_ff && has_parity(mode_ff) &&
                        (rx_extra_ff != par_of(rx_data, mode_ff));

    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN || !ctrl_ff[CTRL_RXON])
        begin
            rx_st_ff      <= S_IDLE;
            rx_sub_ff     <= 4'h0;
            rx_shifter_ff <= 8'h00;
            rx_idx_ff     <= 3'h0;
            rx_extra_ff   <= 1'b0;
            rx_prev_ff    <= 1'b1;
        end
        else
        begin
            rx_prev_ff <= rx_s_ff;
            if (tick)
                rx_sub_ff <= rx_sub_ff + 4'h1;
            if (rx_st_ff == S_IDLE)
            begin
                if (rx_prev_ff && !rx_s_ff && !rx_err_any)
                begin
                    rx_st_ff  <= S_START;
                    rx_sub_ff <= 4'h0;
                    rx_idx_ff <= 3'h0;
                end
            end
            else if (rx_sample)
            begin
                unique case (rx_st_ff)
                    S_START: rx_st_ff <= rx_s_ff ? S_IDLE : S_DATA;
                    S_DATA:
                    begin
                        rx_shifter_ff <= {rx_s_ff, rx_shifter_ff[7:1]};
                        rx_idx_ff     <= rx_idx_ff + 3'h1;
                        if (rx_idx_ff == last_data_idx(mode_ff))
                            rx_st_ff <= (has_parity(mode_ff) || has_mpb(mode_ff)) ? S_EXTRA
                                                                                  : S_STOP;
                    end
                    S_EXTRA:
                    begin
                        rx_extra_ff <= rx_s_ff;
                        rx_st_ff    <= S_STOP;
                    end
                    // A second stop bit is not checked, so reception ends here.
                    S_STOP:  rx_st_ff <= S_IDLE;
                    default: rx_st_ff <= S_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
        begin
            rx_buffer_ff <= 8'h00;
            mpb_rx_ff    <= 1'b0;
        end
        else if (rx_done && !rx_buf_full_flag_ff)
        begin
            rx_buffer_ff <= rx_data;
            mpb_rx_ff    <= has_mpb(mode_ff) && rx_extra_ff;
        end
    end
endmodule : async_serial_tx_rx_core

//--- verif/serial_core_asserts.sv
// Assertion checker for the serial core; it sees the core's ports only.
// Assumes asynchronous mode and software driving the register port.
module serial_core_asserts
    import serial_pkg::*;
(
    input wire logic       CLK_SYS,
    input wire logic       RSTN,
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WR_DATA,
    input wire logic       WR_STB,
    input wire logic       RD_STB,
    input wire logic [7:0] RD_DATA,
    input wire logic       RX_LINE,
    input wire logic       TX_LINE,
    input wire logic       SCK_I,
    input wire logic       SCK_O,
    input wire logic       SCK_OE,
    input wire logic       IRQ_RX_FULL,
    input wire logic       IRQ_TX_EMPTY,
    input wire logic       IRQ_TX_DONE
);
    // ------------------------------------------------------------------
    // Control shadow
    // ------------------------------------------------------------------
    // The control word is rebuilt from writes, as the checker cannot look inside.
    logic [7:0] ctl_ff;
    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
            ctl_ff <= RST_CTRL;
        else if (WR_STB && ADDR == OFS_CTRL)
            ctl_ff <= WR_DATA;
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    AST_RX_IRQ_GATE: assert property ((!ctl_ff[CTRL_RXIE]) [*2] |-> !IRQ_RX_FULL)
        else $error("receive request without its enable");
    AST_TXE_IRQ_GATE: assert property ((!ctl_ff[CTRL_TXIE]) [*2] |-> !IRQ_TX_EMPTY)
        else $error("empty request without its enable");
    AST_TXD_IRQ_GATE: assert property ((!ctl_ff[CTRL_TDIE]) [*2] |-> !IRQ_TX_DONE)
        else $error("done request without its enable");
    AST_LOW_BIT_LEN: assert property ($fell(TX_LINE) |-> (!TX_LINE || !ctl_ff[CTRL_TXON]) [*8])
        else $error("low bit on transmit line too short");
    AST_TX_IDLE_OFF: assert property ((!ctl_ff[CTRL_TXON]) [*3] |-> TX_LINE)
        else $error("transmit line low while transmitter off");
    AST_CKOUT_ON: assert property ((ctl_ff[1:0] == CK_INT_OUT) [*3] |-> SCK_OE)
        else $error("clock pin not driven in output mode");
    AST_CKOUT_OFF: assert property ((ctl_ff[1:0] != CK_INT_OUT) [*3] |-> !SCK_OE)
        else $error("clock pin driven outside output mode");
    AST_DONE_MARK: assert property ($rose(IRQ_TX_DONE) |-> TX_LINE && $past(TX_LINE))
        else $error("done request while line not at mark");
    AST_UNMAPPED_RD: assert property (RD_STB && ADDR[2:1] == 2'b11 |=> RD_DATA == 8'h00)
        else $error("unmapped read not zero");
    AST_RD_HOLD: assert property (!$past(RD_STB) |-> $stable(RD_DATA))
        else $error("read data changed without a read");
    COV_RX: cover property ($rose(IRQ_RX_FULL));
    COV_DONE: cover property ($rose(IRQ_TX_DONE));
    COV_CKOUT: cover property ($rose(SCK_OE));
endmodule : serial_core_asserts

bind async_serial_tx_rx_core serial_core_asserts chk_u (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
    .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA),
    .RX_LINE(RX_LINE), .TX_LINE(TX_LINE), .SCK_I(SCK_I), .SCK_O(SCK_O), .SCK_OE(SCK_OE),
    .IRQ_RX_FULL(IRQ_RX_FULL), .IRQ_TX_EMPTY(IRQ_TX_EMPTY), .IRQ_TX_DONE(IRQ_TX_DONE));

//--- verif/serial_peer.sv
// Remote serial peer: sends frames on the core's receive line and captures its output.
// Assumes the bench sets the bit length in system clocks and the capture length.
module serial_peer
(
    input  wire logic clk,
    input  wire logic tx_line,
    output logic      rx_line,
    output logic      sck
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------------
    // Line model
    // ------------------------------------------------------------------
    int          bit_clks = 16;
    int          tx_len   = 10;
    logic        ext_on   = 1'b0;
    logic [11:0] cap;
    logic [11:0] frames[$];
    initial
    begin
        rx_line = 1'b1;
        sck     = 1'b0;
    end
    always #100 sck = ext_on ? ~sck : 1'b0;
    task automatic send(input logic [11:0] v, input int n);
        for (int i = 0; i < n; i++)
        begin
            rx_line <= v[i];
            repeat (bit_clks) @(posedge clk);
        end
    endtask : send
    always
    begin
        @(negedge tx_line);
        cap = '0;
        repeat (bit_clks / 2) @(posedge clk);
        for (int i = 0; i < tx_len; i++)
        begin
            cap[i] = tx_line;
            if (i < tx_len - 1)
                repeat (bit_clks) @(posedge clk);
        end
        frames.push_back(cap);
    end
endmodule : serial_peer

//--- verif/tb.sv
// Self-checking bench for the serial core: register tasks plus a remote serial peer.
// Assumes the divisor is 0, so one bit is 16 system clocks on the internal clock.
module tb
    import serial_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk_sys = 1'b0;
    logic       rstn;
    logic [2:0] addr;
    logic [7:0] wr_data;
    logic       wr_stb;
    logic       rd_stb;
    logic [7:0] rd_data;
    logic       rx_line;
    logic       tx_line;
    logic       sck;
    logic       sck_o;
    logic       sck_oe;
    logic       irq_rx_full;
    logic       irq_tx_empty;
    logic       irq_tx_done;
    int         n_mismatch = 0;
    int         tests_run  = 0;
    int         cyc        = 0;
    logic [7:0] d;
    logic [11:0] f;
    logic [7:0] md[5];
    logic [11:0] fr[5];
    int         nb[5];
    logic [7:0] ex[5];
    logic [7:0] es[5];
    always #25 clk_sys = ~clk_sys;
    async_serial_tx_rx_core dut_u (.CLK_SYS(clk_sys), .RSTN(rstn), .ADDR(addr),
        .WR_DATA(wr_data), .WR_STB(wr_stb), .RD_STB(rd_stb), .RD_DATA(rd_data),
        .RX_LINE(rx_line), .TX_LINE(tx_line), .SCK_I(sck), .SCK_O(sck_o), .SCK_OE(sck_oe),
        .IRQ_RX_FULL(irq_rx_full), .IRQ_TX_EMPTY(irq_tx_empty), .IRQ_TX_DONE(irq_tx_done));
    serial_peer peer_u (.clk(clk_sys), .tx_line(tx_line), .rx_line(rx_line), .sck(sck));
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    function automatic logic [7:0] m(input int b);
        return 8'h01 << b;
    endfunction : m
    function automatic logic irq_v(input int k);
        return (k == 0) ? irq_rx_full : (k == 1) ? irq_tx_empty : irq_tx_done;
    endfunction : irq_v
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        addr    <= a;
        wr_data <= v;
        wr_stb  <= 1'b1;
        @(posedge clk_sys);
        wr_stb  <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        @(posedge clk_sys);
        v = rd_data;
    endtask : rd
    // Polling is bounded so a silent request ends as a mismatch, not a hang.
    task automatic wait_irq(input int k);
        int i;
        repeat (2) @(posedge clk_sys);
        for (i = 0; i < 4000 && irq_v(k) !== 1'b1; i++)
            @(posedge clk_sys);
        chk("irq_wait", {7'h0, irq_v(k)}, 8'h01);
    endtask : wait_irq
    task automatic conclude();
        $display("mismatches %0d checks %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            conclude();
        end
    end
    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial
    begin
        md = '{m(MODE_SEVEN) | m(MODE_PAR), m(MODE_PAR) | m(MODE_MP),
               m(MODE_PAR) | m(MODE_ODD) | m(MODE_STOP2), 8'h00, m(MODE_MP)};
        fr = '{12'({2'b10, 7'h55, 1'b0}), 12'({1'b1, 5'h13, 1'b0}),
               {2'b11, 1'b0, 8'h0f, 1'b0}, 12'({2'b10, 8'h81, 1'b0}),
               12'({2'b11, 8'hc3, 1'b0})};
        nb = '{10, 7, 12, 11, 11};
        ex = '{8'h55, 8'h13, 8'h0f, 8'h81, 8'hc3};
        es = '{8'h40, 8'h40, 8'h08, 8'h10, 8'h42};
        rstn = 1'b0; addr = 3'h0; wr_data = 8'h00; wr_stb = 1'b0; rd_stb = 1'b0;
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        rd(OFS_STATUS, d); chk("status_reset", d, 8'h84);
        wr(3'h6, 8'h5a); rd(3'h6, d); chk("unmapped", d, 8'h00);
        wr(OFS_DIV, 8'h00);
        wr(OFS_CTRL, m(CTRL_TXIE) | m(CTRL_RXIE) | m(CTRL_TXON) | m(CTRL_RXON)
            | m(CTRL_TDIE) | {6'h0, CK_INT_OUT});
        repeat (3) @(posedge clk_sys);
        chk("clk_out_en", {7'h0, sck_oe}, 8'h01);
        @(posedge sck_o);
        repeat (7) @(posedge clk_sys);
        chk("clk_out_hi", {7'h0, sck_o}, 8'h01);
        repeat (2) @(posedge clk_sys);
        chk("clk_out_lo", {7'h0, sck_o}, 8'h00);
        // Both paths run at once; the second byte lands while the first is shifting.
        fork
            begin
                wr(OFS_TXBUF, 8'ha5); wr(OFS_STATUS, 8'h00);
                wait_irq(1);
                wr(OFS_TXBUF, 8'h3c); wr(OFS_STATUS, 8'h00);
                wait_irq(2);
            end
            peer_u.send(12'({2'b01, 8'h96, 1'b0}), 10);
        join
        wait_irq(0);
        rd(OFS_RXBUF, d); chk("rx_data", d, 8'h96);
        rd(OFS_STATUS, d); chk("tx_done_flag_set", d & m(ST_TX_DONE_FLAG), m(ST_TX_DONE_FLAG));
        chk("tx_count", 8'(peer_u.frames.size()), 8'h02);
        for (int i = 0; i < 2 && peer_u.frames.size() > 0; i++)
        begin
            f = peer_u.frames.pop_front();
            chk("tx_data", f[8:1], (i == 0) ? 8'ha5 : 8'h3c);
            chk("tx_start_stop", {6'h0, f[9], f[0]}, 8'h02);
        end
        peer_u.send(12'({2'b01, 8'h11, 1'b0}), 10);
        rd(OFS_STATUS, d); chk("overrun", d & 8'h60, 8'h60);
        wr(OFS_CTRL, m(CTRL_RXIE));
        rd(OFS_STATUS, d); chk("rx_off_flags", d & 8'h60, 8'h60);
        rd(OFS_RXBUF, d); chk("rx_off_buf", d, 8'h96);
        wr(OFS_STATUS, 8'h00);
        repeat (2) @(posedge clk_sys);
        chk("irq_cleared", {7'h0, irq_rx_full}, 8'h00);
        wr(OFS_CTRL, m(CTRL_TXON));
        wr(OFS_TXBUF, 8'h77); wr(OFS_STATUS, 8'h00); wr(OFS_CTRL, 8'h00);
        rd(OFS_STATUS, d); chk("tx_off_empty", d & m(ST_TX_BUF_EMPTY_FLAG), m(ST_TX_BUF_EMPTY_FLAG));
        for (int i = 0; i < 5; i++)
        begin
            wr(OFS_CTRL, 8'h00); wr(OFS_MODE, md[i]);
            wr(OFS_CTRL, m(CTRL_RXON)); wr(OFS_STATUS, 8'h00);
            peer_u.send(fr[i], nb[i]);
            rd(OFS_RXBUF, d); chk("fmt_data", d, ex[i]);
            rd(OFS_STATUS, d); chk("fmt_status", d & 8'h7a, es[i]);
            chk("irq_masked", {7'h0, irq_rx_full}, 8'h00);
            chk("clk_pin_port", {7'h0, sck_oe}, 8'h00);
        end
        peer_u.tx_len = 11;
        wr(OFS_CTRL, m(CTRL_TXON)); wr(OFS_TXBUF, 8'h5e); wr(OFS_STATUS, 8'h01);
        repeat (200) @(posedge clk_sys);
        f = peer_u.frames.pop_back();
        chk("tx_mp_data", f[8:1], 8'h5e);
        chk("tx_mp_bits", {5'h0, f[10:9], f[0]}, 8'h06);
        wr(OFS_CTRL, 8'h00); wr(OFS_MODE, 8'h00); wr(OFS_STATUS, 8'h00);
        peer_u.ext_on = 1'b1;
        peer_u.bit_clks = 64;
        wr(OFS_CTRL, m(CTRL_RXON) | {6'h0, CK_EXT});
        peer_u.send(12'({2'b01, 8'h6e, 1'b0}), 10);
        rd(OFS_RXBUF, d); chk("ext_clk_data", d, 8'h6e);
        chk("ext_clk_pin", {7'h0, sck_oe}, 8'h00);
        conclude();
    end
endmodule : tb
